// File: core/tasl_top.sv
// trip alarm status logger with axi4-lite slave and interrupt
`timescale 1ns/10ps
module tasl_top #(
   parameter int LOG_DEPTH = tasl_pkg::LOG_DEPTH
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] trip_in,
   input  wire logic [15:0] misc_code_in,
   input  wire logic        run_request_input,
   input  wire logic        keypad_down,
   output logic             alarm_active,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // pin synchronisers: three stages, change accepted when 2 and 3 agree
   logic [15:0] trip_s1, trip_s2, trip_s3, trip_q;
   logic [2:0]  run_sy, key_sy;
   logic        run_q, key_q, run_d, key_d;
   logic [15:0] misc_s1, misc_s2, misc_s3, misc_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trip_s1 <= 16'h0000;
         trip_s2 <= 16'h0000;
         trip_s3 <= 16'h0000;
         trip_q  <= 16'h0000;
         run_sy  <= 3'h0;
         key_sy  <= 3'h0;
         run_q   <= 1'b0;
         key_q   <= 1'b0;
         misc_s1 <= 16'h0000;
         misc_s2 <= 16'h0000;
         misc_s3 <= 16'h0000;
         misc_q  <= 16'h0000;
      end else begin
         trip_s1 <= trip_in;
         trip_s2 <= trip_s1;
         trip_s3 <= trip_s2;
         trip_q  <= (trip_s2 & trip_s3) | (trip_q & (trip_s2 | trip_s3));
         run_sy  <= {run_sy[1:0], run_request_input};
         key_sy  <= {key_sy[1:0], keypad_down};
         if (run_sy[1] == run_sy[2]) begin
            run_q <= run_sy[2];
         end
         if (key_sy[1] == key_sy[2]) begin
            key_q <= key_sy[2];
         end
         misc_s1 <= misc_code_in;
         misc_s2 <= misc_s1;
         misc_s3 <= misc_s2;
         // whole word taken only when stages agree, no torn codes
         if (misc_s2 == misc_s3) begin
            misc_q <= misc_s3;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_d <= 1'b0;
         key_d <= 1'b0;
      end else begin
         run_d <= run_q;
         key_d <= key_q;
      end
   end

   logic run_rise, key_rise;
   assign run_rise = run_q & ~run_d;
   assign key_rise = key_q & ~key_d;

   // trip event detection: bits newly raised this cycle
   logic [15:0] trip_prev, new_bits;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trip_prev <= 16'h0000;
      end else begin
         trip_prev <= trip_q;
      end
   end
   assign new_bits = trip_q & ~trip_prev;

   function automatic logic [15:0] lowest_bit(input logic [15:0] v);
      return v & (~v + 16'h0001);
   endfunction

   // code recorded for an event; misc group replaced by extended code
   function automatic logic [15:0] event_code(input logic [15:0] bits,
                                               input logic [15:0] ext);
      logic [15:0] one;
      one = lowest_bit(bits);
      if (one[tasl_pkg::MISC_BIT] && ext[15:12] == tasl_pkg::EXT_PREFIX) begin
         return ext;
      end
      return one;
   endfunction

   // active trip mask, one bit per trip
   logic [15:0] active_trip_mask;
   logic [15:0] first_trip_capture;
   logic [15:0] most_recent_alarm_code;
   tasl_pkg::tasl_state_e state;
   tasl_pkg::tasl_event_s log_push;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_trip_mask <= tasl_pkg::CODE_CLEAR;
      end else if (run_rise && trip_q == 16'h0000) begin
         active_trip_mask <= tasl_pkg::CODE_CLEAR;
      end else begin
         // sum of one-hot codes equals the or of bits
         active_trip_mask <= trip_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= tasl_pkg::TASL_IDLE;
      end else begin
         case (state)
            tasl_pkg::TASL_IDLE: begin
               if (new_bits != 16'h0000) begin
                  state <= tasl_pkg::TASL_TRIPPED;
               end
            end
            tasl_pkg::TASL_TRIPPED: begin
               if (run_rise && trip_q == 16'h0000) begin
                  state <= tasl_pkg::TASL_IDLE;
               end
            end
            default: state <= tasl_pkg::TASL_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_active <= 1'b0;
      end else begin
         // alarm output and status capture use the same edge
         alarm_active <= (state == tasl_pkg::TASL_TRIPPED) ||
                         (new_bits != 16'h0000);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_trip_capture <= tasl_pkg::CODE_CLEAR;
      end else if (run_rise) begin
         first_trip_capture <= tasl_pkg::CODE_CLEAR;
      end else if (first_trip_capture == 16'h0000 && new_bits != 16'h0000) begin
         first_trip_capture <= lowest_bit(new_bits);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         most_recent_alarm_code <= tasl_pkg::CODE_CLEAR;
      end else if (new_bits != 16'h0000) begin
         most_recent_alarm_code <= event_code(new_bits, misc_q);
      end else if (key_rise) begin
         most_recent_alarm_code <= tasl_pkg::CODE_CLEAR;
      end
   end

   always_comb begin
      log_push.valid = (new_bits != 16'h0000);
      log_push.code  = lowest_bit(new_bits);
   end

   // axi4-lite slave
   logic [7:0]  aw_addr;
   logic        aw_have, w_have;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [2:0]  irq_stat, irq_mask, irq_ev;
   logic [2:0]  ctrl;
   logic        wr_go;
   logic [3:0]  log_idx;
   logic [15:0] log_data;
   logic        rd_pend;
   logic [7:0]  rd_addr;

   assign wr_go = aw_have && w_have && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tasl_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == tasl_pkg::OFS_IRQ_STAT || aw_addr == tasl_pkg::OFS_IRQ_MASK ||
                aw_addr == tasl_pkg::OFS_CTRL) begin
               s_axi_bresp <= tasl_pkg::RESP_OKAY;
            end else begin
               s_axi_bresp <= tasl_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // irq events: trip, first capture, run clear
   assign irq_ev = {run_rise, (first_trip_capture == 16'h0000) && (new_bits != 16'h0000),
                    new_bits != 16'h0000};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= 3'h0;
         irq_mask <= tasl_pkg::IRQ_MASK_RST;
         ctrl     <= 3'h0;
      end else begin
         if (wr_go && aw_addr == tasl_pkg::OFS_IRQ_STAT && w_strb[0]) begin
            irq_stat <= (irq_stat & ~w_data[2:0]) | irq_ev;
         end else begin
            irq_stat <= irq_stat | irq_ev;
         end
         if (wr_go && aw_addr == tasl_pkg::OFS_IRQ_MASK && w_strb[0]) begin
            irq_mask <= w_data[2:0];
         end
         if (wr_go && aw_addr == tasl_pkg::OFS_CTRL && w_strb[0]) begin
            ctrl <= w_data[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // index from the handshake address so the log word is ready with rvalid
   assign log_idx = 4'((s_axi_araddr - tasl_pkg::OFS_LOG0) >> 2);

   tasl_log_mem #(
      .DEPTH (LOG_DEPTH)
   ) u_log (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .push     (log_push),
      .rd_index (log_idx),
      .rd_data  (log_data)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= tasl_pkg::RESP_OKAY;
         rd_pend       <= 1'b0;
         rd_addr       <= 8'h00;
      end else begin
         s_axi_arready <= !s_axi_arready && !rd_pend && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            rd_pend <= 1'b1;
            rd_addr <= s_axi_araddr;
         end else if (rd_pend) begin
            // log read data registered one cycle after address capture
            rd_pend      <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tasl_pkg::RESP_OKAY;
            case (rd_addr)
               tasl_pkg::OFS_ACTIVE:   s_axi_rdata <= {16'h0000, active_trip_mask};
               tasl_pkg::OFS_FIRST:    s_axi_rdata <= {16'h0000, first_trip_capture};
               tasl_pkg::OFS_RECENT:   s_axi_rdata <= {16'h0000, most_recent_alarm_code};
               tasl_pkg::OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
               tasl_pkg::OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
               tasl_pkg::OFS_CTRL:     s_axi_rdata <= {29'h0, ctrl};
               default: begin
                  if (rd_addr >= tasl_pkg::OFS_LOG0 && rd_addr <= tasl_pkg::OFS_LOG_LAST &&
                      rd_addr[1:0] == 2'h0) begin
                     s_axi_rdata <= {16'h0000, log_data};
                  end else begin
                     s_axi_rdata <= 32'h0000_0000;
                     s_axi_rresp <= tasl_pkg::RESP_SLVERR;
                  end
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   a_mask_clear_run: assert property (@(posedge aclk) disable iff (!aresetn)
      (run_rise && trip_q == 16'h0000) |=> active_trip_mask == 16'h0000)
      else $error("active mask not cleared by run request");
   a_mask_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
      !run_rise |=> active_trip_mask == $past(trip_q))
      else $error("active mask does not follow trips");
   a_first_held: assert property (@(posedge aclk) disable iff (!aresetn)
      (first_trip_capture != 16'h0000 && !run_rise) |=> $stable(first_trip_capture))
      else $error("first trip capture overwritten");
   a_first_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      run_rise |=> first_trip_capture == 16'h0000)
      else $error("first trip capture not cleared");
   a_first_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (first_trip_capture == 16'h0000 && new_bits != 16'h0000 && !run_rise)
      |=> first_trip_capture == $past(lowest_bit(new_bits)))
      else $error("first trip capture did not load");
   a_recent_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (key_rise && new_bits == 16'h0000) |=> most_recent_alarm_code == 16'h0000)
      else $error("most recent alarm not cleared by keypad");
   a_alarm_same: assert property (@(posedge aclk) disable iff (!aresetn)
      (new_bits != 16'h0000) |=> alarm_active && most_recent_alarm_code != 16'h0000)
      else $error("alarm and record not simultaneous");
   a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (alarm_active && trip_q != 16'h0000) |=> alarm_active)
      else $error("trip released while cause active");
   a_alarm_release: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(alarm_active) |-> $past(run_rise, 2))
      else $error("alarm released without run request");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(irq_stat & irq_mask)) |=> irq)
      else $error("interrupt not raised");
   c_trip: cover property (@(posedge aclk) disable iff (!aresetn) new_bits != 16'h0000);
   c_reset_trip: cover property (@(posedge aclk) disable iff (!aresetn)
      state == tasl_pkg::TASL_TRIPPED ##1 state == tasl_pkg::TASL_IDLE);
   c_ext_code: cover property (@(posedge aclk) disable iff (!aresetn)
      most_recent_alarm_code[15:12] == tasl_pkg::EXT_PREFIX);
   c_two_trips: cover property (@(posedge aclk) disable iff (!aresetn)
      $countones(active_trip_mask) > 1);
endmodule

// File: core/tasl_pkg.sv
// package: register map, trip codes and carriers for the trip alarm status logger
// Overview of operation
// - active trip mask tracks live trip inputs every cycle
// - simultaneous trips show as sum of their one-hot codes
// - run request rising with no trip present clears the active mask
// - first-trip capture holds first or only alarm code, later ignored
// - run request rising clears first-trip capture to zero
// - log keeps ten newest alarm events, newest in entry one
// - every trip-status value is sixteen bits wide
// - low byte bits: overspeed through encoder failure
// - high byte bits: field loss through current transformer loss
// - miscellaneous trips give extended F-prefixed code in most recent alarm
// - extended codes include nonzero second digit and FF-prefixed values
// - most recent alarm shows last alarm, cleared by keypad down key
// - after power restore most recent alarm reads all-clear
// - status registers record trip in same cycle as alarm indication
// - trip stays latched until reset, reset only once cause is gone
package tasl_pkg;
   localparam int           TRIP_W        = 16;
   localparam int           LOG_DEPTH     = 10;
   localparam logic [15:0]  CODE_CLEAR    = 16'h0000;
   localparam logic [3:0]   MISC_BIT      = 4'hE;
   localparam logic [3:0]   EXT_PREFIX    = 4'hF;
   // byte offsets
   localparam logic [7:0]   OFS_ACTIVE    = 8'h00;
   localparam logic [7:0]   OFS_FIRST     = 8'h04;
   localparam logic [7:0]   OFS_RECENT    = 8'h08;
   localparam logic [7:0]   OFS_IRQ_STAT  = 8'h0C;
   localparam logic [7:0]   OFS_IRQ_MASK  = 8'h10;
   localparam logic [7:0]   OFS_CTRL      = 8'h14;
   localparam logic [7:0]   OFS_LOG0      = 8'h40;
   localparam logic [7:0]   OFS_LOG_LAST  = 8'h64;
   localparam logic [2:0]   IRQ_W         = 3'h3;
   localparam logic [2:0]   IRQ_MASK_RST  = 3'h0;
   localparam logic [1:0]   RESP_OKAY     = 2'h0;
   localparam logic [1:0]   RESP_SLVERR   = 2'h2;
   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } tasl_event_s;
   typedef enum logic [1:0] {
      TASL_IDLE = 2'b00,
      TASL_TRIPPED = 2'b01
   } tasl_state_e;
endpackage

// File: core/tasl_log_mem.sv
// alarm event log: shift register of recent codes with registered read port
`timescale 1ns/10ps
module tasl_log_mem #(
   parameter int DEPTH = 10
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire tasl_pkg::tasl_event_s push,
   input  wire logic [3:0]  rd_index,
   output logic      [15:0] rd_data
);
   logic [15:0] entry [DEPTH];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry[i] <= tasl_pkg::CODE_CLEAR;
         end
      end else if (push.valid) begin
         for (int i = DEPTH - 1; i > 0; i--) begin
            entry[i] <= entry[i-1];
         end
         entry[0] <= push.code;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data <= 16'h0000;
      end else if (int'(rd_index) < DEPTH) begin
         rd_data <= entry[rd_index];
      end else begin
         rd_data <= 16'h0000;
      end
   end
endmodule

// File: tb/tasl_far_model.sv
// far-side model: trip detectors, start input and keypad
`timescale 1ns/10ps
module tasl_far_model (
   input  wire logic        aclk,
   output logic      [15:0] trip_in,
   output logic      [15:0] misc_code_in,
   output logic             run_request_input,
   output logic             keypad_down
);
   initial begin
      trip_in = 16'h0000;
      misc_code_in = 16'h0000;
      run_request_input = 1'b0;
      keypad_down = 1'b0;
   end
   task automatic set_trip(input logic [15:0] t, input logic [15:0] m);
      @(posedge aclk);
      misc_code_in <= m;
      trip_in <= t;
   endtask
   // level held well past the input synchroniser, then dropped
   task automatic pulse(input bit key);
      @(posedge aclk);
      if (key)
         keypad_down <= 1'b1;
      else
         run_request_input <= 1'b1;
      repeat (6) @(posedge aclk);
      keypad_down <= 1'b0;
      run_request_input <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
endmodule

// File: tb/tasl_tb_top.sv
// self-checking bench for the trip alarm status logger
`timescale 1ns/10ps
module tasl_tb_top;
   localparam int LIMIT = 20000;
   logic        aclk, aresetn, alarm_active, irq;
   logic [15:0] trip_in, misc_code_in;
   logic        run_request_input, keypad_down;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          bad_count, n_checks, cyc, i;
   logic [15:0] ext [13] = '{16'hF001, 16'hF002, 16'hF003, 16'hF004, 16'hF005, 16'hF006,
                             16'hF007, 16'hF009, 16'hF010, 16'hF200, 16'hF300, 16'hF400,
                             16'hFF03};

   tasl_top dut (.aclk(aclk), .aresetn(aresetn), .trip_in(trip_in),
      .misc_code_in(misc_code_in), .run_request_input(run_request_input),
      .keypad_down(keypad_down), .alarm_active(alarm_active), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tasl_far_model far (.aclk(aclk), .trip_in(trip_in), .misc_code_in(misc_code_in),
      .run_request_input(run_request_input), .keypad_down(keypad_down));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic summarize();
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e);
      n_checks++;
      if (rsp !== e) begin
         bad_count++;
         $display("Error %s response expected %h seen %h", nm, e, rsp);
      end
   endtask

   // handshakes judged at the rising edge, released right after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 0;
      while (!b) begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready) begin
            b = 1;
            rsp = bresp;
            bready <= 1'b0;
         end
      end
   endtask
   task automatic rdr(input logic [7:0] a);
      bit r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 0;
      while (!r) begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready) begin
            r = 1;
            rsp = rresp;
            rd = rdata;
            rready <= 1'b0;
         end
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      rdr(a);
      chk_resp(nm, tasl_pkg::RESP_OKAY);
      chk(nm, e, rd);
   endtask
   task automatic settle();
      repeat (8) @(posedge aclk);
   endtask

   initial begin
      bad_count = 0;
      n_checks = 0;
      cyc = 0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(tasl_pkg::OFS_RECENT, 32'h0, "recent");
      rchk(tasl_pkg::OFS_ACTIVE, 32'h0, "active");
      chk("irq", 32'h0, {31'h0, irq});
      wr(tasl_pkg::OFS_CTRL, 32'h5);
      chk_resp("ctrl wr", tasl_pkg::RESP_OKAY);
      rchk(tasl_pkg::OFS_CTRL, 32'h5, "ctrl");
      wr(tasl_pkg::OFS_ACTIVE, 32'hFFFF);
      chk_resp("ro wr", tasl_pkg::RESP_SLVERR);
      rchk(tasl_pkg::OFS_ACTIVE, 32'h0, "active ro");
      rdr(8'h68);
      chk_resp("unmapped", tasl_pkg::RESP_SLVERR);
      chk("unmapped", 32'h0, rd);
      for (i = 0; i < 16; i++) begin
         far.set_trip(16'(32'h1 << i), 16'h0000);
         settle();
         chk("alarm", 32'h1, {31'h0, alarm_active});
         rchk(tasl_pkg::OFS_ACTIVE, 32'h1 << i, "active bit");
         rchk(tasl_pkg::OFS_FIRST, 32'h1 << i, "first");
         rchk(tasl_pkg::OFS_RECENT, 32'h1 << i, "recent");
         rchk(tasl_pkg::OFS_LOG0, 32'h1 << i, "log1");
         far.set_trip(16'h0000, 16'h0000);
         settle();
         chk("alarm held", 32'h1, {31'h0, alarm_active});
         far.pulse(0);
         chk("alarm reset", 32'h0, {31'h0, alarm_active});
         rchk(tasl_pkg::OFS_ACTIVE, 32'h0, "active clr");
         rchk(tasl_pkg::OFS_FIRST, 32'h0, "first clr");
      end
      for (i = 0; i < 10; i++)
         rchk(8'(int'(tasl_pkg::OFS_LOG0) + 4 * i), 32'h1 << (15 - i), "log");
      wr(tasl_pkg::OFS_IRQ_STAT, 32'h7);
      wr(tasl_pkg::OFS_IRQ_MASK, 32'h1);
      rchk(tasl_pkg::OFS_IRQ_MASK, 32'h1, "irq mask");
      chk("irq idle", 32'h0, {31'h0, irq});
      far.set_trip(16'h0008, 16'h0000);
      settle();
      chk("irq set", 32'h1, {31'h0, irq});
      far.set_trip(16'h0028, 16'h0000);
      settle();
      far.set_trip(16'h0128, 16'h0000);
      settle();
      rchk(tasl_pkg::OFS_ACTIVE, 32'h0128, "active sum");
      rchk(tasl_pkg::OFS_FIRST, 32'h0008, "first kept");
      rchk(tasl_pkg::OFS_RECENT, 32'h0100, "recent last");
      rchk(tasl_pkg::OFS_LOG0, 32'h0100, "log1");
      rchk(8'(int'(tasl_pkg::OFS_LOG0) + 4), 32'h0020, "log2");
      rdr(tasl_pkg::OFS_IRQ_STAT);
      chk("irq stat", 32'h1, rd & 32'h1);
      wr(tasl_pkg::OFS_IRQ_STAT, 32'h7);
      repeat (2) @(posedge aclk);
      chk("irq clr", 32'h0, {31'h0, irq});
      far.pulse(0);
      rchk(tasl_pkg::OFS_FIRST, 32'h0, "first run");
      rchk(tasl_pkg::OFS_ACTIVE, 32'h0128, "active kept");
      chk("alarm kept", 32'h1, {31'h0, alarm_active});
      chk("irq masked", 32'h0, {31'h0, irq});
      far.set_trip(16'h0000, 16'h0000);
      settle();
      far.pulse(0);
      rchk(tasl_pkg::OFS_ACTIVE, 32'h0, "active clr");
      far.pulse(1);
      rchk(tasl_pkg::OFS_RECENT, 32'h0, "recent key");
      for (i = 0; i < 13; i++) begin
         far.set_trip(16'h4000, ext[i]);
         settle();
         rchk(tasl_pkg::OFS_RECENT, {16'h0, ext[i]}, "recent ext");
         rchk(tasl_pkg::OFS_ACTIVE, 32'h4000, "active misc");
         far.set_trip(16'h0000, 16'h0000);
         settle();
         far.pulse(0);
      end
      summarize();
   end
endmodule
